// *** logic/mic_pkg.sv ***
package mic_pkg;
   // ------------------------------------------------------------
   // source counts and layout of the flat source index space
   // ------------------------------------------------------------
   localparam int N_CORES    = 4;
   localparam int N_INT      = 256;
   localparam int N_EXT      = 12;
   localparam int N_MSI      = 64;
   localparam int MSI_GROUPS = 4;
   localparam int MSI_EVENTS = 32;
   localparam int N_MSG      = 16;
   localparam int MSG_GROUPS = 2;
   localparam int N_IPI      = 4;
   localparam int N_TMR      = 8;
   localparam int TMR_GROUPS = 2;

   localparam int BASE_INT = 0;
   localparam int BASE_EXT = BASE_INT + N_INT;
   localparam int BASE_MSI = BASE_EXT + N_EXT;
   localparam int BASE_MSG = BASE_MSI + N_MSI;
   localparam int BASE_IPI = BASE_MSG + N_MSG;
   localparam int BASE_TMR = BASE_IPI + N_IPI;
   localparam int N_SRC    = BASE_TMR + N_TMR;

   // ------------------------------------------------------------
   // widths and special values
   // ------------------------------------------------------------
   localparam int ID_W    = 9;
   localparam int PRIO_W  = 4;
   localparam int MSG_W   = 32;
   localparam int TMR_W   = 32;
   localparam int MSI_IW  = 6;
   localparam int MSI_EW  = 5;
   localparam int MSG_IW  = 4;
   localparam int IPI_IW  = 2;

   localparam logic [ID_W-1:0]   SPURIOUS_ID = 9'h1ff;
   localparam logic [ID_W-1:0]   ID_RESET    = 9'h000;
   localparam logic [PRIO_W-1:0] PRIO_RESET  = 4'h0;
   localparam logic [MSG_W-1:0]  MSG_RESET   = 32'h0000_0000;
   localparam logic [TMR_W-1:0]  TMR_RESET   = 32'h0000_0000;
   localparam logic [MSI_EVENTS-1:0] EV_NONE = 32'h0000_0000;
endpackage

// *** logic/multicore_interrupt_controller.sv ***
`timescale 1ns/10ps
module multicore_interrupt_controller (
   // clock and reset
   input  wire logic                                               clk_sys,
   input  wire logic                                               reset,
   // level sources
   input  wire logic [mic_pkg::N_INT-1:0]                          int_src,
   input  wire logic [mic_pkg::N_EXT-1:0]                          ext_irq,
   // shared message-signalled events
   input  wire logic                                               msi_wr,
   input  wire logic [mic_pkg::MSI_IW-1:0]                         msi_index,
   input  wire logic [mic_pkg::MSI_EW-1:0]                         msi_event,
   input  wire logic [mic_pkg::N_MSI-1:0][mic_pkg::MSI_EVENTS-1:0] msi_coal_mask,
   // messaging channels
   input  wire logic                                               msg_wr,
   input  wire logic [mic_pkg::MSG_IW-1:0]                         msg_wr_index,
   input  wire logic [mic_pkg::MSG_W-1:0]                          msg_wr_data,
   input  wire logic                                               msg_rd,
   input  wire logic [mic_pkg::MSG_IW-1:0]                         msg_rd_index,
   output logic      [mic_pkg::MSG_W-1:0]                          msg_rd_data,
   // inter-processor events
   input  wire logic                                               ipi_issue,
   input  wire logic [mic_pkg::IPI_IW-1:0]                         ipi_event,
   input  wire logic [mic_pkg::N_CORES-1:0]                        ipi_core_mask,
   input  wire logic [mic_pkg::N_IPI-1:0][mic_pkg::N_CORES-1:0]    ipi_recipient,
   // global timers
   input  wire logic                                               rtc_in,
   input  wire logic [mic_pkg::N_TMR-1:0]                          tmr_enable,
   input  wire logic [mic_pkg::N_TMR-1:0]                          tmr_use_rtc,
   input  wire logic [mic_pkg::N_TMR-1:0][mic_pkg::TMR_W-1:0]      tmr_reload,
   // per-source configuration
   input  wire logic [mic_pkg::N_SRC-1:0]                          src_enable,
   input  wire logic [mic_pkg::N_SRC-1:0][mic_pkg::PRIO_W-1:0]     src_prio,
   input  wire logic [mic_pkg::N_SRC-1:0][mic_pkg::N_CORES-1:0]    src_dest,
   // per-core delivery
   input  wire logic [mic_pkg::N_CORES-1:0]                        core_ack,
   output logic      [mic_pkg::N_CORES-1:0]                        core_irq,
   output logic      [mic_pkg::N_CORES-1:0][mic_pkg::ID_W-1:0]     core_irq_id,
   output logic      [mic_pkg::N_CORES-1:0][mic_pkg::PRIO_W-1:0]   core_irq_prio,
   output logic      [mic_pkg::N_CORES-1:0]                        core_ack_valid,
   output logic      [mic_pkg::N_CORES-1:0][mic_pkg::ID_W-1:0]     core_ack_id
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [mic_pkg::N_EXT-1:0] ext_meta_r;
   logic [mic_pkg::N_EXT-1:0] ext_sync_r;
   logic                      rtc_meta_r;
   logic                      rtc_sync_r;
   logic                      rtc_prev_r;
   logic                      rtc_tick;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ext_meta_r <= '0;
         ext_sync_r <= '0;
         rtc_meta_r <= 1'b0;
         rtc_sync_r <= 1'b0;
         rtc_prev_r <= 1'b0;
      end else begin
         ext_meta_r <= ext_irq;
         ext_sync_r <= ext_meta_r;
         rtc_meta_r <= rtc_in;
         rtc_sync_r <= rtc_meta_r;
         rtc_prev_r <= rtc_sync_r;
      end
   end

   // one count per rising rtc edge, so rtc must be slower than half clk_sys
   assign rtc_tick = rtc_sync_r & ~rtc_prev_r;

   // ------------------------------------------------------------
   // state declarations
   // ------------------------------------------------------------
   logic [mic_pkg::N_MSI-1:0][mic_pkg::MSI_EVENTS-1:0] msi_ev_r, msi_ev_nxt;
   logic [mic_pkg::N_MSI-1:0]                          msi_pend_r, msi_pend_nxt;
   logic [mic_pkg::N_MSG-1:0][mic_pkg::MSG_W-1:0]      msg_data_r, msg_data_nxt;
   logic [mic_pkg::N_MSG-1:0]                          msg_pend_r, msg_pend_nxt;
   logic [mic_pkg::MSG_W-1:0]                          msg_rd_data_r, msg_rd_data_nxt;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::N_IPI-1:0]    ipi_pend_r, ipi_pend_nxt;
   logic [mic_pkg::N_TMR-1:0][mic_pkg::TMR_W-1:0]      tmr_cnt_r, tmr_cnt_nxt;
   logic [mic_pkg::N_TMR-1:0]                          tmr_pend_r, tmr_pend_nxt;

   logic [mic_pkg::N_SRC-1:0]                          src_pend;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::N_SRC-1:0]    ack_hit;
   logic [mic_pkg::N_CORES-1:0]                        best_v;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::ID_W-1:0]     best_id;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::PRIO_W-1:0]   best_p;

   // ------------------------------------------------------------
   // shared message-signalled sources
   // ------------------------------------------------------------
   always_comb begin
      msi_ev_nxt   = msi_ev_r;
      msi_pend_nxt = msi_pend_r;
      for (int i = 0; i < mic_pkg::N_MSI; i++) begin
         for (int c = 0; c < mic_pkg::N_CORES; c++) begin
            if (ack_hit[c][mic_pkg::BASE_MSI + i]) begin
               msi_pend_nxt[i] = 1'b0;
            end
         end
         // one slot per event; an empty coalescing set fires on any event
         if (msi_wr && msi_index == mic_pkg::MSI_IW'(i)) begin
            msi_ev_nxt[i][msi_event] = 1'b1;
            if (msi_coal_mask[i] == mic_pkg::EV_NONE) begin
               msi_pend_nxt[i] = 1'b1;
               msi_ev_nxt[i]   = mic_pkg::EV_NONE;
            end
         end
         if (msi_coal_mask[i] != mic_pkg::EV_NONE &&
             (msi_ev_nxt[i] & msi_coal_mask[i]) == msi_coal_mask[i]) begin
            msi_pend_nxt[i] = 1'b1;
            msi_ev_nxt[i]   = mic_pkg::EV_NONE;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         msi_ev_r   <= '0;
         msi_pend_r <= '0;
      end else begin
         msi_ev_r   <= msi_ev_nxt;
         msi_pend_r <= msi_pend_nxt;
      end
   end

   // ------------------------------------------------------------
   // messaging channels
   // ------------------------------------------------------------
   always_comb begin
      msg_data_nxt    = msg_data_r;
      msg_pend_nxt    = msg_pend_r;
      msg_rd_data_nxt = msg_rd_data_r;
      if (msg_rd) begin
         msg_rd_data_nxt            = msg_data_r[msg_rd_index];
         msg_pend_nxt[msg_rd_index] = 1'b0;
      end
      // write after read: a fresh message in the read cycle stays pending
      if (msg_wr) begin
         msg_data_nxt[msg_wr_index] = msg_wr_data;
         msg_pend_nxt[msg_wr_index] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         msg_data_r    <= '0;
         msg_pend_r    <= '0;
         msg_rd_data_r <= mic_pkg::MSG_RESET;
      end else begin
         msg_data_r    <= msg_data_nxt;
         msg_pend_r    <= msg_pend_nxt;
         msg_rd_data_r <= msg_rd_data_nxt;
      end
   end

   assign msg_rd_data = msg_rd_data_r;

   // ------------------------------------------------------------
   // inter-processor events
   // ------------------------------------------------------------
   always_comb begin
      ipi_pend_nxt = ipi_pend_r;
      for (int c = 0; c < mic_pkg::N_CORES; c++) begin
         for (int e = 0; e < mic_pkg::N_IPI; e++) begin
            if (ack_hit[c][mic_pkg::BASE_IPI + e]) begin
               ipi_pend_nxt[c][e] = 1'b0;
            end
         end
         // every selected recipient latches the event in the same cycle
         if (ipi_issue && ipi_core_mask[c] && ipi_recipient[ipi_event][c]) begin
            ipi_pend_nxt[c][ipi_event] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ipi_pend_r <= '0;
      end else begin
         ipi_pend_r <= ipi_pend_nxt;
      end
   end

   // ------------------------------------------------------------
   // global timers
   // ------------------------------------------------------------
   always_comb begin
      tmr_cnt_nxt  = tmr_cnt_r;
      tmr_pend_nxt = tmr_pend_r;
      for (int t = 0; t < mic_pkg::N_TMR; t++) begin
         for (int c = 0; c < mic_pkg::N_CORES; c++) begin
            if (ack_hit[c][mic_pkg::BASE_TMR + t]) begin
               tmr_pend_nxt[t] = 1'b0;
            end
         end
         if (!tmr_enable[t]) begin
            tmr_cnt_nxt[t] = tmr_reload[t];
         end else if (!tmr_use_rtc[t] || rtc_tick) begin
            if (tmr_cnt_r[t] == mic_pkg::TMR_RESET) begin
               tmr_cnt_nxt[t]  = tmr_reload[t];
               tmr_pend_nxt[t] = 1'b1;
            end else begin
               tmr_cnt_nxt[t] = tmr_cnt_r[t] - 32'h0000_0001;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tmr_cnt_r  <= '0;
         tmr_pend_r <= '0;
      end else begin
         tmr_cnt_r  <= tmr_cnt_nxt;
         tmr_pend_r <= tmr_pend_nxt;
      end
   end

   // ------------------------------------------------------------
   // selection per core
   // ------------------------------------------------------------
   // ipi slots of src_pend stay zero; those come from each core's own latch
   always_comb begin
      src_pend = '0;
      src_pend[mic_pkg::BASE_INT +: mic_pkg::N_INT] = int_src;
      src_pend[mic_pkg::BASE_EXT +: mic_pkg::N_EXT] = ext_sync_r;
      src_pend[mic_pkg::BASE_MSI +: mic_pkg::N_MSI] = msi_pend_r;
      src_pend[mic_pkg::BASE_MSG +: mic_pkg::N_MSG] = msg_pend_r;
      src_pend[mic_pkg::BASE_TMR +: mic_pkg::N_TMR] = tmr_pend_r;
   end

   // flat scan: long combinational path traded for a fixed one-cycle answer
   always_comb begin
      logic cand;
      cand    = 1'b0;
      best_v  = '0;
      best_id = '0;
      best_p  = '0;
      ack_hit = '0;
      for (int c = 0; c < mic_pkg::N_CORES; c++) begin
         for (int s = 0; s < mic_pkg::N_SRC; s++) begin
            if (s >= mic_pkg::BASE_IPI && s < mic_pkg::BASE_TMR) begin
               cand = ipi_pend_r[c][s - mic_pkg::BASE_IPI];
            end else begin
               cand = src_pend[s] && src_dest[s][c];
            end
            cand = cand && src_enable[s];
            // strict compare keeps the earlier, lower index on a tie
            if (cand && (!best_v[c] || src_prio[s] > best_p[c])) begin
               best_v[c]  = 1'b1;
               best_id[c] = mic_pkg::ID_W'(s);
               best_p[c]  = src_prio[s];
            end
         end
         for (int s = 0; s < mic_pkg::N_SRC; s++) begin
            ack_hit[c][s] = core_ack[c] && best_v[c] && best_id[c] == mic_pkg::ID_W'(s);
         end
      end
   end

   // ------------------------------------------------------------
   // delivery and acknowledge
   // ------------------------------------------------------------
   logic [mic_pkg::N_CORES-1:0]                        irq_r, irq_nxt;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::ID_W-1:0]     irq_id_r, irq_id_nxt;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::PRIO_W-1:0]   irq_prio_r, irq_prio_nxt;
   logic [mic_pkg::N_CORES-1:0]                        ack_v_r, ack_v_nxt;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::ID_W-1:0]     ack_id_r, ack_id_nxt;

   always_comb begin
      irq_nxt      = best_v;
      irq_id_nxt   = best_id;
      irq_prio_nxt = best_p;
      ack_v_nxt    = core_ack;
      ack_id_nxt   = ack_id_r;
      for (int c = 0; c < mic_pkg::N_CORES; c++) begin
         if (core_ack[c]) begin
            // a level source may drop before the ack; answer spurious, touch nothing
            ack_id_nxt[c] = best_v[c] ? best_id[c] : mic_pkg::SPURIOUS_ID;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq_r      <= '0;
         irq_id_r   <= '0;
         irq_prio_r <= '0;
         ack_v_r    <= '0;
         ack_id_r   <= '0;
      end else begin
         irq_r      <= irq_nxt;
         irq_id_r   <= irq_id_nxt;
         irq_prio_r <= irq_prio_nxt;
         ack_v_r    <= ack_v_nxt;
         ack_id_r   <= ack_id_nxt;
      end
   end

   assign core_irq       = irq_r;
   assign core_irq_id    = irq_id_r;
   assign core_irq_prio  = irq_prio_r;
   assign core_ack_valid = ack_v_r;
   assign core_ack_id    = ack_id_r;

endmodule

// *** sim/mic_core_model.sv ***
`timescale 1ns/10ps
module mic_core_model (
   // clock
   input  wire logic       clk_sys,
   // bench controls
   input  wire logic       auto_en,
   input  wire logic [1:0] delay,
   // delivery side
   input  wire logic [3:0] core_irq,
   output logic      [3:0] core_ack
);
   logic [3:0]      ack_r    = 4'h0;
   logic [3:0][1:0] wait_cnt = '0;
   assign core_ack = ack_r;
   // a core acks once per request; skipping the cycle after an ack avoids a double take
   always @(negedge clk_sys) begin
      for (int c = 0; c < 4; c++) begin
         if (auto_en && core_irq[c] && !ack_r[c] && wait_cnt[c] >= delay) begin
            ack_r[c]    <= 1'b1;
            wait_cnt[c] <= 2'h0;
         end else begin
            ack_r[c] <= 1'b0;
            // count never passes delay, so two bits hold it
            if (auto_en && core_irq[c] && !ack_r[c]) begin
               wait_cnt[c] <= wait_cnt[c] + 2'h1;
            end
         end
      end
   end
endmodule

// *** sim/multicore_interrupt_controller_bench.sv ***
`timescale 1ns/10ps
module multicore_interrupt_controller_bench;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                                               clk_sys = 1'b0;
   logic                                               reset = 1'b1;
   logic [mic_pkg::N_INT-1:0]                          int_src;
   logic [mic_pkg::N_EXT-1:0]                          ext_irq;
   logic                                               msi_wr, msg_wr, msg_rd, ipi_issue, rtc_in;
   logic [mic_pkg::MSI_IW-1:0]                         msi_index;
   logic [mic_pkg::MSI_EW-1:0]                         msi_event;
   logic [mic_pkg::N_MSI-1:0][mic_pkg::MSI_EVENTS-1:0] msi_coal_mask;
   logic [mic_pkg::MSG_IW-1:0]                         msg_wr_index, msg_rd_index;
   logic [mic_pkg::MSG_W-1:0]                          msg_wr_data, msg_rd_data, d;
   logic [mic_pkg::IPI_IW-1:0]                         ipi_event;
   logic [mic_pkg::N_CORES-1:0]                        ipi_core_mask, core_ack, man_ack, mdl_ack;
   logic [mic_pkg::N_IPI-1:0][mic_pkg::N_CORES-1:0]    ipi_recipient;
   logic [mic_pkg::N_TMR-1:0]                          tmr_enable, tmr_use_rtc;
   logic [mic_pkg::N_TMR-1:0][mic_pkg::TMR_W-1:0]      tmr_reload;
   logic [mic_pkg::N_SRC-1:0]                          src_enable;
   logic [mic_pkg::N_SRC-1:0][mic_pkg::PRIO_W-1:0]     src_prio;
   logic [mic_pkg::N_SRC-1:0][mic_pkg::N_CORES-1:0]    src_dest;
   logic [mic_pkg::N_CORES-1:0]                        core_irq, core_ack_valid;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::ID_W-1:0]     core_irq_id, core_ack_id;
   logic [mic_pkg::N_CORES-1:0][mic_pkg::PRIO_W-1:0]   core_irq_prio;
   logic [mic_pkg::ID_W-1:0]                           id;
   logic [1:0]                                         mdl_wait = 2'h0;
   logic                                               auto_en = 1'b0;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   int a, b, k, c;
   assign core_ack = man_ack | mdl_ack;
   always #4 clk_sys = ~clk_sys;
   multicore_interrupt_controller u_multicore_interrupt_controller (.*);
   mic_core_model u_mic_core_model (.clk_sys(clk_sys), .auto_en(auto_en), .delay(mdl_wait),
      .core_irq(core_irq), .core_ack(mdl_ack));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // the run is a few hundred cycles; the ceiling only catches a hang
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // select bit n names core n; only configured recipients of the event latch it
   function automatic logic [3:0] ipi_exp(input logic [3:0] sel, input logic [3:0] rcp);
      return sel & rcp;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic see(input int cr, input int src);
      chk(core_irq[cr], 32'(src >= 0));
      if (src >= 0) chk(core_irq_id[cr], src);
   endtask
   task automatic ack(input int cr, output logic [mic_pkg::ID_W-1:0] got);
      man_ack[cr] = 1'b1;
      cyc(1);
      man_ack[cr] = 1'b0;
      chk(core_ack_valid[cr], 1);
      got = core_ack_id[cr];
   endtask
   task automatic pulse_msi(input int m, input int e);
      msi_index = 6'(m);
      msi_event = 5'(e);
      msi_wr = 1'b1;
      cyc(1);
      msi_wr = 1'b0;
   endtask
   task automatic idle();
      int_src = '0;
      ext_irq = '0;
      msi_wr = 1'b0;
      msi_index = '0;
      msi_event = '0;
      msi_coal_mask = '0;
      msg_wr = 1'b0;
      msg_rd = 1'b0;
      msg_wr_index = '0;
      msg_rd_index = '0;
      msg_wr_data = '0;
      ipi_issue = 1'b0;
      ipi_event = '0;
      ipi_core_mask = '0;
      ipi_recipient = '0;
      rtc_in = 1'b0;
      tmr_enable = '0;
      tmr_use_rtc = '0;
      tmr_reload = '0;
      src_enable = '0;
      src_prio = '0;
      src_dest = {mic_pkg::N_SRC{4'h1}};
      man_ack = '0;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      void'($urandom(21));
      idle();
      cyc(20);
      reset = 1'b0;
      cyc(2);
      see(0, -1);
      ack(0, id);
      chk(id, mic_pkg::SPURIOUS_ID);
      $display("test spurious done");
      a = $urandom_range(100, 0);
      b = a + 1 + $urandom_range(150, 0);
      int_src[a] = 1'b1;
      int_src[b] = 1'b1;
      src_enable[a] = 1'b1;
      src_enable[b] = 1'b1;
      cyc(3);
      see(0, a);
      src_prio[b] = 4'hf;
      cyc(3);
      see(0, b);
      chk(core_irq_prio[0], 4'hf);
      src_enable[b] = 1'b0;
      cyc(3);
      see(0, a);
      src_dest[a] = 4'h2;
      cyc(3);
      see(1, a);
      see(0, -1);
      ack(1, id);
      chk(id, a);
      cyc(2);
      see(1, a);
      int_src[a] = 1'b0;
      ack(1, id);
      chk(id, mic_pkg::SPURIOUS_ID);
      int_src[a] = 1'b1;
      cyc(3);
      see(1, a);
      idle();
      $display("test priority done");
      repeat (4) begin
         k = $urandom_range(15, 0);
         c = k % 4;
         d = $urandom();
         src_enable[mic_pkg::BASE_MSG + k] = 1'b1;
         src_dest[mic_pkg::BASE_MSG + k] = 4'h1 << c;
         msg_wr_index = 4'(k);
         msg_wr_data = d;
         msg_wr = 1'b1;
         cyc(1);
         msg_wr = 1'b0;
         cyc(2);
         see(c, mic_pkg::BASE_MSG + k);
         ack(c, id);
         chk(id, mic_pkg::BASE_MSG + k);
         cyc(2);
         see(c, mic_pkg::BASE_MSG + k);
         msg_rd_index = 4'(k);
         msg_rd = 1'b1;
         cyc(1);
         msg_rd = 1'b0;
         chk(msg_rd_data, d);
         cyc(2);
         see(c, -1);
         msg_wr = 1'b1;
         msg_wr_data = ~d;
         cyc(1);
         msg_wr = 1'b0;
         msg_rd = 1'b1;
         cyc(1);
         msg_rd = 1'b0;
         chk(msg_rd_data, ~d);
         idle();
      end
      $display("test messaging done");
      for (int g = 0; g < 4; g++) begin
         k = g * 16 + $urandom_range(15, 0);
         a = $urandom_range(15, 0);
         b = a + 1 + $urandom_range(15, 0);
         msi_coal_mask[k] = (32'h1 << a) | (32'h1 << b);
         src_enable[mic_pkg::BASE_MSI + k] = 1'b1;
         pulse_msi(k, a);
         cyc(2);
         see(0, -1);
         pulse_msi(k, b);
         cyc(2);
         see(0, mic_pkg::BASE_MSI + k);
         ack(0, id);
         chk(id, mic_pkg::BASE_MSI + k);
         cyc(2);
         see(0, -1);
         idle();
         src_enable[mic_pkg::BASE_MSI + k] = 1'b1;
         pulse_msi(k, b);
         cyc(2);
         see(0, mic_pkg::BASE_MSI + k);
         ack(0, id);
         idle();
      end
      $display("test shared msi done");
      for (int e = 0; e < 4; e++) begin
         src_enable[mic_pkg::BASE_IPI + e] = 1'b1;
         ipi_recipient[e] = 4'hf;
         ipi_recipient[e][e] = 1'b0;
         ipi_event = 2'(e);
         ipi_core_mask = 4'($urandom_range(15, 1));
         ipi_issue = 1'b1;
         cyc(1);
         ipi_issue = 1'b0;
         cyc(2);
         chk(core_irq, ipi_exp(ipi_core_mask, ipi_recipient[e]));
         for (c = 0; c < 4; c++) begin
            if (core_irq[c]) begin
               ack(c, id);
               chk(id, mic_pkg::BASE_IPI + e);
            end
         end
         cyc(2);
         chk(core_irq, 4'h0);
         idle();
      end
      $display("test inter-processor done");
      auto_en = 1'b1;
      repeat (6) begin
         a = $urandom_range(11, 0);
         mdl_wait = 2'($urandom_range(3, 0));
         src_enable[mic_pkg::BASE_EXT + a] = 1'b1;
         ext_irq[a] = 1'b1;
         for (k = 0; k < 12 && core_ack_valid[0] !== 1'b1; k++) cyc(1);
         chk(core_ack_valid[0], 1);
         chk(core_ack_id[0], mic_pkg::BASE_EXT + a);
         idle();
         cyc(8);
      end
      auto_en = 1'b0;
      $display("test external done");
      for (int t = 0; t < 8; t++) begin
         src_enable[mic_pkg::BASE_TMR + t] = 1'b1;
         tmr_use_rtc[t] = t[0];
         tmr_reload[t] = 32'(t);
         tmr_enable[t] = 1'b1;
         cyc(4);
         if (t[0]) begin
            see(0, -1);
            rtc_in = 1'b1;
            cyc(3);
            rtc_in = 1'b0;
            cyc(4);
         end
         see(0, mic_pkg::BASE_TMR + t);
         tmr_enable[t] = 1'b0;
         ack(0, id);
         chk(id, mic_pkg::BASE_TMR + t);
         cyc(3);
         see(0, -1);
         idle();
      end
      $display("test timers done");
      final_report();
   end
endmodule

// *** sim/multicore_interrupt_controller_chk.sv ***
`timescale 1ns/10ps
module multicore_interrupt_controller_chk (
   // clock and reset
   input wire logic                                           clk_sys,
   input wire logic                                           reset,
   // sources and channels
   input wire logic [mic_pkg::N_SRC-1:0]                      src_enable,
   input wire logic                                           msg_wr,
   input wire logic [mic_pkg::MSG_IW-1:0]                     msg_wr_index,
   input wire logic [mic_pkg::MSG_W-1:0]                      msg_wr_data,
   input wire logic                                           msg_rd,
   input wire logic [mic_pkg::MSG_IW-1:0]                     msg_rd_index,
   input wire logic [mic_pkg::MSG_W-1:0]                      msg_rd_data,
   // delivery
   input wire logic [mic_pkg::N_CORES-1:0]                    core_ack,
   input wire logic [mic_pkg::N_CORES-1:0]                    core_irq,
   input wire logic [mic_pkg::N_CORES-1:0][mic_pkg::ID_W-1:0] core_irq_id,
   input wire logic [mic_pkg::N_CORES-1:0]                    core_ack_valid,
   input wire logic [mic_pkg::N_CORES-1:0][mic_pkg::ID_W-1:0] core_ack_id
);
   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   sequence s_all_off;
      (src_enable == '0) [*2];
   endsequence
   sequence s_wr_then_rd;
      msg_wr ##1 (msg_rd && !msg_wr && msg_rd_index == $past(msg_wr_index));
   endsequence
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_first_edge_quiet: assert property ($fell(reset) |-> core_irq == '0)
      else $error("irq active at first edge after reset");
   a_ack_gives_valid: assert property (core_ack != '0 |=> core_ack_valid == $past(core_ack))
      else $error("ack not answered next cycle");
   a_no_stray_valid: assert property (core_ack == '0 |=> core_ack_valid == '0)
      else $error("ack valid without ack");
   a_ack_id_hold: assert property (!core_ack[0] |=> $stable(core_ack_id[0]))
      else $error("ack id changed without ack");
   a_rd_data_hold: assert property (!msg_rd |=> $stable(msg_rd_data))
      else $error("read data changed without read");
   a_read_back: assert property (s_wr_then_rd |=> msg_rd_data == $past(msg_wr_data, 2))
      else $error("read did not return written value");
   a_idle_spurious: assert property (s_all_off ##0 core_ack[0] |=>
      core_ack_id[0] == mic_pkg::SPURIOUS_ID)
      else $error("ack with nothing enabled not spurious");
   a_idle_no_irq: assert property (s_all_off |=> core_irq == '0)
      else $error("irq with every source disabled");
   a_irq_id_range: assert property (core_irq[0] |-> core_irq_id[0] < mic_pkg::N_SRC)
      else $error("irq id outside source range");
endmodule
bind multicore_interrupt_controller multicore_interrupt_controller_chk u_chk (.*);
